// File: include/pcm_pkg.sv
package pcm_pkg;
    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int          NBLK     = 8;   // measurement blocks
    localparam int          NWORD    = 64;  // words in the attribute window
    localparam int          TIM_W    = 40;  // profile time counter
    localparam int          CNT_W    = 16;  // profile pass counter
    localparam int          SEC_W    = 32;  // section timer
    localparam int          CLK_NS   = 10;  // clock period in ns
    localparam logic [39:0] TIM_MAX  = 40'hFF_FFFF_FFFF;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [31:0] SEC_MAX  = 32'hFFFF_FFFF;

    // ------------------------------------------------------------------
    // tick intervals, ns, and cycles per tick
    // ------------------------------------------------------------------
    localparam int T10_NS   = 10;
    localparam int T20_NS   = 20;
    localparam int T40_NS   = 40;
    localparam int T80_NS   = 80;
    localparam int T160_NS  = 160;
    localparam int T1600_NS = 1600;
    localparam logic [7:0] T10_CYC   = 8'(T10_NS / CLK_NS);
    localparam logic [7:0] T20_CYC   = 8'(T20_NS / CLK_NS);
    localparam logic [7:0] T40_CYC   = 8'(T40_NS / CLK_NS);
    localparam logic [7:0] T80_CYC   = 8'(T80_NS / CLK_NS);
    localparam logic [7:0] T160_CYC  = 8'(T160_NS / CLK_NS);
    localparam logic [7:0] T1600_CYC = 8'(T1600_NS / CLK_NS);

    // ------------------------------------------------------------------
    // register word addresses and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL   = 8'h00; // [2:0] tick, [3] task mode, [4] clear
    localparam logic [7:0] A_STAT   = 8'h01; // sticky events, write one to clear
    localparam logic [7:0] A_BRKM   = 8'h02; // events qualifying a break
    localparam logic [7:0] A_TRCM   = 8'h03; // events qualifying a trace point
    localparam logic [7:0] A_ALLOC  = 8'h04; // write task id; read [3] refused [2:0] block
    localparam logic [7:0] A_FREE   = 8'h05; // write block index to release
    localparam logic [7:0] A_SEL    = 8'h06; // block picked for readout
    localparam logic [7:0] A_TLO    = 8'h07; // snapshot time [31:0]
    localparam logic [7:0] A_THI    = 8'h08; // snapshot time [39:32]
    localparam logic [7:0] A_CNT    = 8'h09; // [15:0] count, [16] overflow
    localparam logic [7:0] A_SPLO   = 8'h0A; // stack lower bound
    localparam logic [7:0] A_SPHI   = 8'h0B; // stack upper bound
    localparam logic [7:0] A_SEC    = 8'h0C; // section timer
    localparam logic [7:0] A_ATTR   = 8'h0D; // [5:0] word, [10:8] attribute
    localparam logic [7:0] A_BASE   = 8'h0E; // window base word address
    localparam logic [7:0] A_TSTK   = 8'h10; // +block: {hi,lo} task stack
    localparam int         C_CLR    = 4;
    localparam int         C_MODE   = 3;

    // event bits
    localparam int EV_PROF  = 0;
    localparam int EV_PERF  = 1;
    localparam int EV_ACC   = 2;
    localparam int EV_UNINI = 3;
    localparam int EV_STACK = 4;
    localparam int EV_TRACE = 5;
    localparam int EV_TSTK  = 6;
    localparam int EV_DISP  = 7;

    typedef enum logic [2:0] {
        PCM_RW    = 3'b000,
        PCM_RO    = 3'b001,
        PCM_WO    = 3'b010,
        PCM_DIS   = 3'b011,
        PCM_OSONL = 3'b100
    } pcm_attr_t;
endpackage : pcm_pkg

// File: core/pcm_monitor.sv
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pcm_monitor
    import pcm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // target execution
    input  wire logic        task_valid,
    input  wire logic [7:0]  cur_task,
    input  wire logic        fn_active,
    input  wire logic [2:0]  fn_block,
    input  wire logic        fn_entry,
    input  wire logic        sec_start,
    input  wire logic        sec_run,
    input  wire logic        brk_stop,
    // target bus and stack
    input  wire logic        tb_valid,
    input  wire logic        tb_write,
    input  wire logic        tb_os,
    input  wire logic [15:0] tb_addr,
    input  wire logic        sp_valid,
    input  wire logic [15:0] sp,
    input  wire logic        trace_full,
    // event qualifiers
    output logic             brk_req,
    output logic             trc_req,
    output logic      [7:0]  evt_status
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]                tick_sel;
        logic                      task_mode;
        logic [7:0]                tick_cnt;
        logic [7:0]                status;
        logic [7:0]                brk_mask;
        logic [7:0]                trc_mask;
        logic [NBLK-1:0]           used;
        logic [NBLK-1:0][7:0]      owner;
        logic [NBLK-1:0][TIM_W-1:0] tim;
        logic [NBLK-1:0][CNT_W-1:0] cnt;
        logic [NBLK-1:0]           ovf;
        logic [NBLK-1:0][TIM_W-1:0] tim_snap;
        logic [NBLK-1:0][CNT_W-1:0] cnt_snap;
        logic [NBLK-1:0]           ovf_snap;
        logic                      refused;
        logic [2:0]                last_blk;
        logic [2:0]                sel;
        logic [15:0]               sp_lo;
        logic [15:0]               sp_hi;
        logic [NBLK-1:0][31:0]     tstk;
        logic [SEC_W-1:0]          sec_time;
        logic [15:0]               base;
        logic [NWORD-1:0][2:0]     attr;
        logic [NWORD-1:0]          written;
        logic [7:0]                prev_task;
        logic                      task_seen;
        logic [31:0]               rdata;
        logic                      brk_req;
        logic                      trc_req;
    } pcm_state_t;

    pcm_state_t r;
    pcm_state_t next_r;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // block owning a task id, {hit, index}
    function automatic logic [3:0] pcm_find(input logic [7:0] id,
                                            input logic [NBLK-1:0] used,
                                            input logic [NBLK-1:0][7:0] owner);
        logic [3:0] res;
        res = 4'h0;
        for (int i = NBLK - 1; i >= 0; i--) begin
            if (used[i] && owner[i] == id) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction : pcm_find

    // cycles per tick for each selection
    function automatic logic [7:0] pcm_div(input logic [2:0] sel);
        case (sel)
            3'h0:    return T10_CYC;
            3'h1:    return T20_CYC;
            3'h2:    return T40_CYC;
            3'h3:    return T80_CYC;
            3'h4:    return T160_CYC;
            3'h5:    return T1600_CYC;
            default: return T10_CYC;
        endcase
    endfunction : pcm_div

    // ------------------------------------------------------------------
    // decode of the current cycle
    // ------------------------------------------------------------------
    logic [3:0]  task_hit;
    logic        act;
    logic [2:0]  act_idx;
    logic        entry;
    logic        tick;
    logic        clr_now;
    logic        ctrl_wr;
    logic [15:0] woff;
    logic        in_win;
    logic [5:0]  widx;
    logic [2:0]  wattr;
    logic        ro_write;
    logic        disp;
    logic [7:0]  ev;

    // active block and entry per mode
    always_comb begin
        task_hit = pcm_find(cur_task, r.used, r.owner);
        disp     = task_valid && r.task_seen && cur_task != r.prev_task;
        if (r.task_mode) begin
            act     = task_valid && task_hit[3];
            act_idx = task_hit[2:0];
            entry   = disp && task_hit[3];
        end else begin
            act     = fn_active;
            act_idx = fn_block;
            entry   = fn_entry;
        end
        ctrl_wr  = reg_wr && reg_addr == A_CTRL;
        clr_now  = ctrl_wr && (reg_wdata[C_CLR] || reg_wdata[2:0] != r.tick_sel);
        tick     = r.tick_cnt == pcm_div(r.tick_sel) - 8'h01;
        woff     = tb_addr - r.base;
        in_win   = woff < 16'(NWORD);
        widx     = woff[5:0];
        wattr    = r.attr[widx];
        ro_write = tb_valid && tb_write && in_win && wattr == PCM_RO;
    end

    // event detection, one cycle pulses
    always_comb begin
        ev = 8'h00;
        ev[EV_PROF]  = (act && tick && r.tim[act_idx] == TIM_MAX)
                     || (entry && r.cnt[act_idx] == CNT_MAX);
        ev[EV_PERF]  = sec_run && r.sec_time == SEC_MAX;
        if (tb_valid && in_win) begin
            case (wattr)
                PCM_RO:    ev[EV_ACC] = tb_write;
                PCM_WO:    ev[EV_ACC] = !tb_write;
                PCM_DIS:   ev[EV_ACC] = 1'b1;
                PCM_OSONL: ev[EV_ACC] = !tb_os;
                default:   ev[EV_ACC] = 1'b0;
            endcase
            ev[EV_UNINI] = !tb_write && !r.written[widx];
        end
        ev[EV_STACK] = sp_valid && (sp < r.sp_lo || sp > r.sp_hi);
        ev[EV_TRACE] = trace_full;
        for (int j = 0; j < NBLK; j++) begin
            if (tb_valid && tb_write && task_valid && r.used[j]
                && r.owner[j] != cur_task
                && tb_addr >= r.tstk[j][15:0] && tb_addr <= r.tstk[j][31:16]) begin
                ev[EV_TSTK] = 1'b1;
            end
        end
        ev[EV_DISP]  = disp;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        // prescaler free runs; entries are not aligned to it, so an entry
        // may gain or lose up to a tick at each end
        next_r.tick_cnt = tick ? 8'h00 : r.tick_cnt + 8'h01;
        // profile counters run beside the target, never holding it
        if (act && tick) begin
            if (r.tim[act_idx] == TIM_MAX) begin
                next_r.ovf[act_idx] = 1'b1;
            end else begin
                next_r.tim[act_idx] = r.tim[act_idx] + 40'h1;
            end
        end
        if (entry) begin
            if (r.cnt[act_idx] == CNT_MAX) begin
                next_r.ovf[act_idx] = 1'b1;
            end else begin
                next_r.cnt[act_idx] = r.cnt[act_idx] + 16'h1;
            end
        end
        // section timer
        if (sec_start) begin
            next_r.sec_time = '0;
        end else if (sec_run && r.sec_time != SEC_MAX) begin
            next_r.sec_time = r.sec_time + 32'h1;
        end
        // memory written marks
        if (tb_valid && tb_write && in_win) begin
            next_r.written[widx] = 1'b1;
        end
        if (task_valid) begin
            next_r.prev_task = cur_task;
            next_r.task_seen = 1'b1;
        end
        // host view refreshed when the target stops, and zeroed by a clear or a new tick interval
        if (brk_stop) begin
            next_r.tim_snap = r.tim;
            next_r.cnt_snap = r.cnt;
            next_r.ovf_snap = r.ovf;
        end
        // register writes
        next_r.refused = r.refused;
        if (reg_wr) begin
            case (reg_addr)
                A_CTRL: begin
                    next_r.tick_sel  = reg_wdata[2:0];
                    next_r.task_mode = reg_wdata[C_MODE];
                end
                A_BRKM:  next_r.brk_mask = reg_wdata[7:0];
                A_TRCM:  next_r.trc_mask = reg_wdata[7:0];
                A_ALLOC: begin
                    if (&r.used) begin
                        next_r.refused = 1'b1;
                    end else begin
                        next_r.refused = 1'b0;
                        for (int i = NBLK - 1; i >= 0; i--) begin
                            if (!r.used[i]) begin
                                next_r.last_blk = 3'(i);
                            end
                        end
                        next_r.used[next_r.last_blk]  = 1'b1;
                        next_r.owner[next_r.last_blk] = reg_wdata[7:0];
                    end
                end
                A_FREE:  next_r.used[reg_wdata[2:0]] = 1'b0;
                A_SEL:   next_r.sel = reg_wdata[2:0];
                A_SPLO:  next_r.sp_lo = reg_wdata[15:0];
                A_SPHI:  next_r.sp_hi = reg_wdata[15:0];
                A_ATTR:  next_r.attr[reg_wdata[5:0]] = reg_wdata[10:8];
                A_BASE: begin
                    next_r.base    = reg_wdata[15:0];
                    next_r.written = '0;
                end
                default: begin
                    if (reg_addr[7:3] == A_TSTK[7:3]) begin
                        next_r.tstk[reg_addr[2:0]] = reg_wdata;
                    end
                end
            endcase
        end
        // clear command or new tick interval wipes every profile result; the section timer keeps counting
        if (clr_now) begin
            next_r.tim      = '0;
            next_r.cnt      = '0;
            next_r.ovf      = '0;
            next_r.tim_snap = '0;
            next_r.cnt_snap = '0;
            next_r.ovf_snap = '0;
            next_r.tick_cnt = 8'h00;
        end
        // sticky status: a new event beats the clear in the same cycle
        next_r.status = r.status & ~((reg_wr && reg_addr == A_STAT) ? reg_wdata[7:0] : 8'h00);
        next_r.status = next_r.status | ev;
        next_r.brk_req = |(ev & r.brk_mask);
        next_r.trc_req = |(ev & r.trc_mask);
        // read data, valid in the cycle after the strobe only
        next_r.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                A_CTRL:  next_r.rdata = {28'h0, r.task_mode, r.tick_sel};
                A_STAT:  next_r.rdata = {24'h0, r.status};
                A_BRKM:  next_r.rdata = {24'h0, r.brk_mask};
                A_TRCM:  next_r.rdata = {24'h0, r.trc_mask};
                A_ALLOC: next_r.rdata = {20'h0, r.used, r.refused, r.last_blk};
                A_SEL:   next_r.rdata = {29'h0, r.sel};
                A_TLO:   next_r.rdata = r.tim_snap[r.sel][31:0];
                A_THI:   next_r.rdata = {24'h0, r.tim_snap[r.sel][39:32]};
                A_CNT:   next_r.rdata = {15'h0, r.ovf_snap[r.sel], r.cnt_snap[r.sel]};
                A_SPLO:  next_r.rdata = {16'h0, r.sp_lo};
                A_SPHI:  next_r.rdata = {16'h0, r.sp_hi};
                A_SEC:   next_r.rdata = r.sec_time;
                A_BASE:  next_r.rdata = {16'h0, r.base};
                default: begin
                    if (reg_addr[7:3] == A_TSTK[7:3]) begin
                        next_r.rdata = r.tstk[reg_addr[2:0]];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r       <= '0;
            r.sp_hi <= 16'hFFFF; // stack check open until configured
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata  = r.rdata;
    assign brk_req    = r.brk_req;
    assign trc_req    = r.trc_req;
    assign evt_status = r.status;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_ro_write;
        ro_write;
    endsequence
    sequence s_flag_acc;
        r.status[EV_ACC] && (brk_req || !$past(r.brk_mask[EV_ACC]));
    endsequence

    property p_ro_viol;
        s_ro_write |=> s_flag_acc;
    endproperty
    a_ro_viol: assert property (p_ro_viol) else $error("ro write not flagged");

    property p_os_only;
        tb_valid && in_win && wattr == PCM_OSONL && tb_os
            && !(reg_wr && reg_addr == A_STAT)
            |=> r.status[EV_ACC] == $past(r.status[EV_ACC]);
    endproperty
    a_os_only: assert property (p_os_only) else $error("os access flagged");

    property p_uninit;
        tb_valid && !tb_write && in_win && !r.written[widx] |=> r.status[EV_UNINI];
    endproperty
    a_uninit: assert property (p_uninit) else $error("unwritten read missed");

    property p_stack;
        sp_valid && sp > r.sp_hi |=> r.status[EV_STACK];
    endproperty
    a_stack: assert property (p_stack) else $error("stack escape missed");

    property p_disp;
        task_valid && r.task_seen && cur_task != r.prev_task
            |=> r.status[EV_DISP] ##1 r.status[EV_DISP] || $past(reg_wr);
    endproperty
    a_disp: assert property (p_disp) else $error("dispatch missed");

    property p_trace_brk;
        trace_full && r.brk_mask[EV_TRACE] |=> brk_req && r.status[EV_TRACE];
    endproperty
    a_trace_brk: assert property (p_trace_brk) else $error("trace full no break");

    property p_clear;
        clr_now |=> r.tim == '0 && r.cnt == '0 && r.ovf == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("results not cleared");

    property p_tick_chg;
        ctrl_wr && reg_wdata[2:0] != r.tick_sel |=> r.cnt_snap == '0 && r.tim == '0;
    endproperty
    a_tick_chg: assert property (p_tick_chg) else $error("tick change kept");

    property p_full;
        reg_wr && reg_addr == A_ALLOC && &r.used |=> r.refused && &r.used;
    endproperty
    a_full: assert property (p_full) else $error("task taken when full");

    property p_sat;
        r.cnt[0] == CNT_MAX && !clr_now |=> r.cnt[0] == CNT_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("count wrapped");

    property p_time;
        act && act_idx == 3'h0 && tick && r.tim[0] != TIM_MAX && !clr_now
            |=> r.tim[0] == $past(r.tim[0]) + 40'h1;
    endproperty
    a_time: assert property (p_time) else $error("time not advanced");

endmodule : pcm_monitor

// File: verification/pcm_target_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// target bus, stack pointer and trace model
// ----------------------------------------------------------------
module pcm_target_model (
    // clock
    input  wire logic        clk,
    // bus access
    output logic             tb_valid,
    output logic             tb_write,
    output logic             tb_os,
    output logic      [15:0] tb_addr,
    // stack and trace
    output logic             sp_valid,
    output logic      [15:0] sp,
    output logic             trace_full
);
    // idle at time zero
    initial begin
        {tb_valid, tb_write, tb_os, sp_valid, trace_full} = '0;
        tb_addr = 16'h0000;
        sp = 16'h0000;
    end
    // one access; released address inverted so stale values never match
    task automatic acc(input logic w, input logic os, input logic [15:0] a);
        tb_valid <= 1'b1;
        tb_write <= w;
        tb_os <= os;
        tb_addr <= a;
        @(posedge clk);
        tb_valid <= 1'b0;
        tb_addr <= ~a;
        @(posedge clk);
    endtask : acc
    // one stack pointer sample
    task automatic stk(input logic [15:0] v);
        sp_valid <= 1'b1;
        sp <= v;
        @(posedge clk);
        sp_valid <= 1'b0;
        sp <= ~v;
        @(posedge clk);
    endtask : stk
    // trace overflow pulse; caller looks at the reply right away
    task automatic trc();
        trace_full <= 1'b1;
        @(posedge clk);
        trace_full <= 1'b0;
    endtask : trc
endmodule : pcm_target_model

// File: verification/pcm_monitor_tb.sv
`timescale 1ns/1ps
module pcm_monitor_tb;
    import pcm_pkg::*;
    logic        clk, resetn, reg_wr, reg_rd, task_valid, fn_active, fn_entry, brk_stop;
    logic [7:0]  reg_addr, cur_task, evt_status;
    logic [2:0]  fn_block;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic        tb_valid, tb_write, tb_os, sp_valid, trace_full, brk_req, trc_req;
    logic        sec_start, sec_run;
    logic [15:0] tb_addr, sp;
    int          n_errors, checked;
    pcm_monitor dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .task_valid(task_valid), .cur_task(cur_task), .fn_active(fn_active),
        .fn_block(fn_block), .fn_entry(fn_entry), .sec_start(sec_start), .sec_run(sec_run),
        .brk_stop(brk_stop), .tb_valid(tb_valid), .tb_write(tb_write), .tb_os(tb_os),
        .tb_addr(tb_addr), .sp_valid(sp_valid), .sp(sp), .trace_full(trace_full),
        .brk_req(brk_req), .trc_req(trc_req), .evt_status(evt_status));
    pcm_target_model tgt_u (.clk(clk), .tb_valid(tb_valid), .tb_write(tb_write),
        .tb_os(tb_os), .tb_addr(tb_addr), .sp_valid(sp_valid), .sp(sp),
        .trace_full(trace_full));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    // a gap cycle follows each strobe so no signal is assigned twice at one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk);
    endtask : rd
    // read one status bit, then clear it by writing one
    task automatic ev(input int b, input logic e);
        rd(A_STAT, d);
        chk("status bit", 32'(e), 32'(d[b]));
        // pin copy looked at once the edge has settled
        #1 chk("status pin", 32'(e), 32'(evt_status[b]));
        wr(A_STAT, 32'h1 << b);
    endtask : ev
    task automatic close_out();
        $display("checked %0d, n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_events();
        rd(A_STAT, d);
        chk("status after reset", 32'h0, d);
        wr(A_BRKM, 32'h20);
        tgt_u.trc();
        #1 chk("break request", 32'h1, 32'(brk_req));
        chk("trace request", 32'h0, 32'(trc_req));
        @(posedge clk);
        ev(EV_TRACE, 1'b1);
        wr(A_BRKM, 32'h0);
        wr(A_TRCM, 32'h20);
        tgt_u.trc();
        #1 chk("trace request", 32'h1, 32'(trc_req));
        chk("break request", 32'h0, 32'(brk_req));
        @(posedge clk);
        ev(EV_TRACE, 1'b1);
        wr(A_TRCM, 32'h0);
        wr(A_SPLO, 32'h100);
        wr(A_SPHI, 32'h200);
        tgt_u.stk(16'h0150);
        ev(EV_STACK, 1'b0);
        tgt_u.stk(16'h00FF);
        ev(EV_STACK, 1'b1);
        tgt_u.stk(16'h0201);
        ev(EV_STACK, 1'b1);
        task_valid <= 1'b1;
        cur_task <= 8'h01;
        @(posedge clk);
        cur_task <= 8'h02;
        repeat (2) @(posedge clk);
        ev(EV_DISP, 1'b1);
        $display("events test done");
    endtask : t_events
    task automatic t_access();
        wr(A_BASE, 32'h0);
        wr(A_ATTR, 32'h101); // word 1 read only
        wr(A_ATTR, 32'h402); // word 2 operating system only
        wr(A_ATTR, 32'h303); // word 3 disabled
        tgt_u.acc(1'b1, 1'b0, 16'h0001);
        ev(EV_ACC, 1'b1);
        tgt_u.acc(1'b1, 1'b1, 16'h0002);
        ev(EV_ACC, 1'b0);
        tgt_u.acc(1'b0, 1'b0, 16'h0002);
        ev(EV_ACC, 1'b1);
        tgt_u.acc(1'b1, 1'b0, 16'h0003);
        ev(EV_ACC, 1'b1);
        tgt_u.acc(1'b1, 1'b0, 16'h0004);
        tgt_u.acc(1'b0, 1'b0, 16'h0004);
        ev(EV_UNINI, 1'b0);
        tgt_u.acc(1'b0, 1'b0, 16'h0005);
        ev(EV_UNINI, 1'b1);
        ev(EV_ACC, 1'b0);
        $display("access test done");
    endtask : t_access
    task automatic t_profile();
        wr(A_CTRL, 32'h10);
        fn_block <= 3'h0;
        fn_active <= 1'b1;
        fn_entry <= 1'b1;
        @(posedge clk);
        fn_entry <= 1'b0;
        repeat (99) @(posedge clk);
        fn_active <= 1'b0;
        brk_stop <= 1'b1;
        @(posedge clk);
        brk_stop <= 1'b0;
        @(posedge clk);
        wr(A_SEL, 32'h0);
        rd(A_TLO, d);
        // 100 cycles at 10 ns ticks, tolerance two ticks plus 100 ns
        chk("time in range", 32'h1, 32'(d >= 88 && d <= 112));
        rd(A_CNT, d);
        chk("pass count", 32'h1, d);
        wr(A_CTRL, 32'h1);
        rd(A_CNT, d);
        chk("count after tick change", 32'h0, d);
        // one entry per cycle runs the pass counter into its ceiling
        fn_entry <= 1'b1;
        repeat (65536) @(posedge clk);
        fn_entry <= 1'b0;
        brk_stop <= 1'b1;
        @(posedge clk);
        brk_stop <= 1'b0;
        @(posedge clk);
        rd(A_CNT, d);
        chk("saturated count", 32'h1FFFF, d);
        ev(EV_PROF, 1'b1);
        // section timer counts each running cycle from its start pulse
        sec_start <= 1'b1;
        @(posedge clk);
        sec_start <= 1'b0;
        sec_run <= 1'b1;
        repeat (10) @(posedge clk);
        sec_run <= 1'b0;
        rd(A_SEC, d);
        chk("section time", 32'hA, d);
        $display("profile test done");
    endtask : t_profile
    task automatic t_alloc();
        wr(A_CTRL, 32'h9);
        for (int i = 0; i < 9; i++) begin
            wr(A_ALLOC, 32'(8'h20 + i));
            rd(A_ALLOC, d);
            chk("alloc reply", (i == 8) ? 32'h1FF : 32'(i),
                (i == 8) ? 32'(d[11:3]) : 32'(d[3:0]));
        end
        // block 0 belongs to another task than the running one
        wr(A_TSTK, 32'h0040_0030);
        tgt_u.acc(1'b1, 1'b0, 16'h0035);
        ev(EV_TSTK, 1'b1);
        $display("alloc test done");
    endtask : t_alloc
    // ----------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #1_000_000;
        n_errors++;
        close_out();
    end
    initial begin
        {resetn, reg_wr, reg_rd, task_valid, fn_active, fn_entry, brk_stop, sec_start, sec_run} = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        cur_task = 8'h00;
        fn_block = 3'h0;
        n_errors = 0;
        checked = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_events();
        t_access();
        t_profile();
        t_alloc();
        close_out();
    end
endmodule : pcm_monitor_tb
